/* File: bench/port_config_space_decode_tb.sv */
// self-checking bench for the port configuration space decoder with a word model
// assumes a short side-effect delay so every deferred action is seen within a few cycles
`timescale 1ns/1ps
`default_nettype none
module port_config_space_decode_tb;
  localparam int D = 8;
  localparam logic [12:0] OFFS [7] = '{13'h0050, 13'h0188, 13'h00D4, 13'h0190, 13'h0180, 13'h0200, 13'h01FC};
  logic        i_clock;
  logic        i_rst;
  logic [15:0] i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_cpl;
  logic        o_hot_reset;
  logic        o_fund_reset;
  logic [3:0]  o_link_disable;
  logic [3:0]  o_link_retrain;
  logic [3:0]  o_full_retrain;
  logic [31:0] taken;
  logic [31:0] rng;
  logic [3:0]  dis_m;
  logic [31:0] mem [int];
  int          n_errors;
  int          comparisons;
  int          n_wr;

  port_config_space_decode #(.SIDE_EFFECT_DELAY(D)) dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cpl(o_cpl), .o_hot_reset(o_hot_reset),
    .o_fund_reset(o_fund_reset), .o_link_disable(o_link_disable), .o_link_retrain(o_link_retrain),
    .o_full_retrain(o_full_retrain));
  root_cpl_sink root (.i_clock(i_clock), .i_rst(i_rst), .i_cpl(o_cpl), .o_taken_q(taken));

  always #4 i_clock = ~i_clock;

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic bit defd(logic [15:0] a);
    logic [12:0] o;
    o = {a[12:2], 2'b00};
    if (a[15]) return 1'b0;
    if (o <= 13'h003C || (o >= 13'h0040 && o <= 13'h0050) || (o >= 13'h0064 && o <= 13'h0070)) return 1'b1;
    if ((o >= 13'h00C0 && o <= 13'h00C4) || (o >= 13'h00F0 && o <= 13'h0108) || o == 13'h0190) return 1'b1;
    if (a[14:13] == 2'b00) return o >= 13'h0180 && o <= 13'h0188;
    return o >= 13'h00D0 && o <= 13'h00DC;
  endfunction : defd

  function automatic logic [14:0] outs();
    return {o_cpl, o_hot_reset, o_fund_reset, o_link_disable, o_link_retrain, o_full_retrain};
  endfunction : outs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // the bus is scrambled once released so a stale address or data word cannot pass
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr    <= 1'b0;
    i_addr  <= ~a;
    i_wdata <= ~d;
    #1;
    n_wr++;
    check(o_cpl, 1'b1, "write completion");
    if (defd(a) && a[12:2] != 11'h061) mem[{a[15:2], 2'b00}] = d;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    i_addr <= ~a;
    #1;
    check(o_rdata, exp, "read data");
  endtask : rd

  // defined words never written hold no known value, so they are not read
  task automatic rdm(input logic [15:0] a);
    logic [15:0] k;
    k = {a[15:2], 2'b00};
    if (!defd(a)) rd(a, 32'h0000_0000);
    else if (mem.exists(k)) rd(a, mem[k]);
  endtask : rdm

  task automatic side(input logic [15:0] a, input logic [31:0] d, input logic [14:0] extra);
    logic [14:0] f;
    logic [14:0] e;
    logic [3:0]  old;
    int          p;
    f   = extra;
    old = dis_m;
    p   = int'(a[14:13]);
    if (!a[15] && a[12:2] == 11'h060 && p == 0) begin
      f[13] = d[0];
      f[12] = d[1];
    end
    if (!a[15] && a[12:2] == 11'h014) begin
      f[4+p]   = d[5];
      dis_m[p] = d[4];
    end
    if (!a[15] && a[12:2] == 11'h064) f[p] = d[0];
    wr(a, d);
    for (int k = 2; k <= D + 3; k++) begin
      @(posedge i_clock);
      #1;
      e = {1'b0, ((k == D + 1) ? f[13:12] : 2'b00), ((k > D) ? dis_m : old), ((k == D + 1) ? f[7:0] : 8'h00)};
      check(outs(), e, "action outputs");
    end
  endtask : side

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #(8 * 20000);
    n_errors++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    logic [15:0] a;
    i_clock = 1'b0;
    i_rst = 1'b1;
    i_addr = 16'h0000;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    rng = 32'h0000_8AD5;
    dis_m = 4'h0;
    repeat (15) @(posedge i_clock);
    #1;
    check(outs(), 15'h0000, "outputs in reset");
    check(o_rdata, 32'h0000_0000, "read data in reset");
    @(posedge i_clock);
    i_rst <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      r = xs();
      a = {r[2:0], 13'h0000} | {3'b000, OFFS[int'(r[7:4]) % 7]};
      side(a, xs(), 15'h0000);
      rdm(a);
      rdm(a ^ 16'h8000);
    end
    side(16'h2180, 32'h0000_0003, 15'h0000);
    rd(16'h2180, 32'h0000_0000);
    side(16'h00D8, 32'hFFFF_FFFF, 15'h0000);
    rd(16'h00D8, 32'h0000_0000);
    side(16'h0180, 32'h0000_0002, 15'h0000);
    side(16'h0180, 32'h0000_0001, 15'h0000);
    for (int p = 0; p < 4; p++) begin
      side({p[2:0], 13'h0050}, 32'h0000_0030, 15'h0000);
      side({p[2:0], 13'h0190}, 32'h0000_0001, 15'h0000);
      side({p[2:0], 13'h0050}, 32'h0000_0000, 15'h0000);
    end
    // a later trigger restarts the wait and carries the earlier action with it
    wr(16'h0180, 32'h0000_0001);
    side(16'h2050, {26'h0, 1'b1, dis_m[1], 4'h0}, 15'h2000);
    wr(16'h0180, 32'h0000_0001);
    rd(16'h0184, 32'h0000_0003);
    check(taken, n_wr, "completions taken");
    @(posedge i_clock);
    i_rst <= 1'b1;
    @(posedge i_clock);
    i_rst <= 1'b0;
    dis_m = 4'h0;
    n_wr = 0;
    for (int k = 0; k < D + 4; k++) begin
      @(posedge i_clock);
      #1;
      check(outs(), 15'h0000, "pending action after reset");
    end
    rd(16'h0184, 32'h0000_0000);
    report_and_stop();
  end
endmodule : port_config_space_decode_tb
`default_nettype wire

/* File: bench/root_cpl_sink.sv */
// completion sink standing for the root across the upstream link
// assumes completions arrive as one-cycle pulses in the register port clock domain
`timescale 1ns/1ps
`default_nettype none
module root_cpl_sink (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_cpl,
  output logic      [31:0] o_taken_q
);
  // takes each completion in the cycle it shows, far inside the window before the action
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_taken_q <= 32'h0000_0000;
    end else if (i_cpl) begin
      o_taken_q <= o_taken_q + 32'h0000_0001;
    end
  end
endmodule : root_cpl_sink
`default_nettype wire

/* File: shared/cfg_space_pkg.sv */
// constants for the per-port configuration space decoder of a four-port switch
// assumes one 125 MHz clock and a word-wide register port carrying system addresses
package cfg_space_pkg;

  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 32;
  localparam int OFF_W     = 13;
  localparam int PORT_W    = 2;
  localparam int NUM_PORTS = 4;
  localparam int IDX_W     = 7;
  localparam int MEM_AW    = PORT_W + IDX_W;

  // port bases; bits above the base field select no port when set
  localparam logic [ADDR_W-1:0] PORT0_BASE = 16'h0000;
  localparam logic [ADDR_W-1:0] PORT2_BASE = 16'h2000;
  localparam logic [ADDR_W-1:0] PORT4_BASE = 16'h4000;
  localparam logic [ADDR_W-1:0] PORT6_BASE = 16'h6000;
  localparam logic [ADDR_W-1:0] BASE_MASK  = 16'hE000;

  localparam logic [OFF_W-1:0] OFF_HDR_LAST    = 13'h003C;
  localparam logic [OFF_W-1:0] OFF_PCIE_FIRST  = 13'h0040;
  localparam logic [OFF_W-1:0] OFF_LINK_CTL    = 13'h0050;
  localparam logic [OFF_W-1:0] OFF_PCIE2_FIRST = 13'h0064;
  localparam logic [OFF_W-1:0] OFF_PCIE2_LAST  = 13'h0070;
  localparam logic [OFF_W-1:0] OFF_PM_FIRST    = 13'h00C0;
  localparam logic [OFF_W-1:0] OFF_PM_LAST     = 13'h00C4;
  localparam logic [OFF_W-1:0] OFF_MSI_FIRST   = 13'h00D0;
  localparam logic [OFF_W-1:0] OFF_MSI_LAST    = 13'h00DC;
  localparam logic [OFF_W-1:0] OFF_SSID_FIRST  = 13'h00F0;
  localparam logic [OFF_W-1:0] OFF_AER_LAST    = 13'h0108;
  localparam logic [OFF_W-1:0] OFF_SW_CTL      = 13'h0180;
  localparam logic [OFF_W-1:0] OFF_SW_STS      = 13'h0184;
  localparam logic [OFF_W-1:0] OFF_TEST_MODE   = 13'h0188;
  localparam logic [OFF_W-1:0] OFF_PHY_LSTATE0 = 13'h0190;

  localparam int HOT_RESET_BIT     = 0;
  localparam int FUND_RESET_BIT    = 1;
  localparam int LINK_DISABLE_BIT  = 4;
  localparam int LINK_RETRAIN_BIT  = 5;
  localparam int FULL_RETRAIN_BIT  = 0;

  // pending action vector: two switch-wide bits, then four bits per port
  localparam int ACT_HOT      = 0;
  localparam int ACT_FUND     = 1;
  localparam int ACT_PORT0    = 2;
  localparam int ACT_DIS_UPD  = 0;
  localparam int ACT_DIS_VAL  = 1;
  localparam int ACT_RETRAIN  = 2;
  localparam int ACT_FULL     = 3;
  localparam int ACT_PER_PORT = 4;
  localparam int ACT_W        = ACT_PORT0 + NUM_PORTS * ACT_PER_PORT;

  localparam int CLOCK_KHZ            = 125000;
  localparam int SIDE_EFFECT_DELAY_MS = 1;
  localparam int SIDE_EFFECT_CYCLES   = SIDE_EFFECT_DELAY_MS * CLOCK_KHZ;
  localparam int DELAY_CNT_W          = 17;

  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [ACT_W-1:0]  ACT_RESET   = 18'h0_0000;

endpackage : cfg_space_pkg

/* File: verilog/cfg_word_mem.sv */
// word store for all four port spaces, indexed by port and word of offset
// assumes the caller only writes defined, writable words
`timescale 1ns/1ps
`default_nettype none
module cfg_word_mem (
  input  wire logic                                  i_clock,
  input  wire logic                                  i_rst,
  input  wire logic [cfg_space_pkg::MEM_AW-1:0]      i_addr,
  input  wire logic                                  i_we,
  input  wire logic [cfg_space_pkg::DATA_W-1:0]      i_wdata,
  input  wire logic                                  i_re,
  input  wire logic                                  i_ovr_en,
  input  wire logic [cfg_space_pkg::DATA_W-1:0]      i_ovr_data,
  output logic      [cfg_space_pkg::DATA_W-1:0]      o_rdata_q
);

  logic [cfg_space_pkg::DATA_W-1:0] mem [0:(1<<cfg_space_pkg::MEM_AW)-1];

  // storage itself has no reset, so it maps onto a plain RAM
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata_q <= cfg_space_pkg::RDATA_RESET;
    end else if (i_re) begin
      o_rdata_q <= i_ovr_en ? i_ovr_data : mem[i_addr];
    end
  end

endmodule : cfg_word_mem
`default_nettype wire

/* File: verilog/port_config_space_decode.sv */
// per-port configuration space decoder with deferred side-effect actions
// assumes a single-cycle register port carrying system addresses; read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module port_config_space_decode #(
  parameter int SIDE_EFFECT_DELAY = cfg_space_pkg::SIDE_EFFECT_CYCLES
) (
  input  wire logic                                       i_clock,
  input  wire logic                                       i_rst,
  input  wire logic [cfg_space_pkg::ADDR_W-1:0]           i_addr,
  input  wire logic [cfg_space_pkg::DATA_W-1:0]           i_wdata,
  input  wire logic                                       i_wr,
  input  wire logic                                       i_rd,
  output logic      [cfg_space_pkg::DATA_W-1:0]           o_rdata,
  output logic                                            o_cpl,
  output logic                                            o_hot_reset,
  output logic                                            o_fund_reset,
  output logic      [cfg_space_pkg::NUM_PORTS-1:0]        o_link_disable,
  output logic      [cfg_space_pkg::NUM_PORTS-1:0]        o_link_retrain,
  output logic      [cfg_space_pkg::NUM_PORTS-1:0]        o_full_retrain
);

  localparam int NP = cfg_space_pkg::NUM_PORTS;
  localparam int AW = cfg_space_pkg::ACT_W;
  localparam int DLY_M1 = SIDE_EFFECT_DELAY - 1;

  // offset map per port type; MSI only downstream, switch-wide registers only upstream
  function automatic logic offset_defined(input logic up, input logic [cfg_space_pkg::OFF_W-1:0] off);
    logic common;
    logic up_only;
    logic down_only;
    common    = (off <= cfg_space_pkg::OFF_HDR_LAST) ||
                (off >= cfg_space_pkg::OFF_PCIE_FIRST && off <= cfg_space_pkg::OFF_LINK_CTL) ||
                (off >= cfg_space_pkg::OFF_PCIE2_FIRST && off <= cfg_space_pkg::OFF_PCIE2_LAST) ||
                (off >= cfg_space_pkg::OFF_PM_FIRST && off <= cfg_space_pkg::OFF_PM_LAST) ||
                (off >= cfg_space_pkg::OFF_SSID_FIRST && off <= cfg_space_pkg::OFF_AER_LAST) ||
                (off == cfg_space_pkg::OFF_PHY_LSTATE0);
    up_only   = (off >= cfg_space_pkg::OFF_SW_CTL && off <= cfg_space_pkg::OFF_TEST_MODE);
    down_only = (off >= cfg_space_pkg::OFF_MSI_FIRST && off <= cfg_space_pkg::OFF_MSI_LAST);
    return common || (up && up_only) || (!up && down_only);
  endfunction : offset_defined

  // port base decode: bases sit on an 8 KB grid below the mask
  function automatic logic base_is(input logic [cfg_space_pkg::ADDR_W-1:0] a,
                                   input logic [cfg_space_pkg::ADDR_W-1:0] base);
    return (a & cfg_space_pkg::BASE_MASK) == base;
  endfunction : base_is

  wire logic                              hit_p0;
  wire logic                              hit_p2;
  wire logic                              hit_p4;
  wire logic                              hit_p6;
  wire logic                              base_hit;
  wire logic [cfg_space_pkg::PORT_W-1:0]  port_sel;
  wire logic                              is_up;
  wire logic [cfg_space_pkg::OFF_W-1:0]   offset;
  wire logic                              defined;
  wire logic                              sts_hit;
  wire logic [cfg_space_pkg::MEM_AW-1:0]  mem_addr;
  wire logic                              mem_we;
  wire logic                              ovr_en;
  wire logic [cfg_space_pkg::DATA_W-1:0]  ovr_data;
  wire logic                              def_wr;
  wire logic                              sw_ctl_wr;
  wire logic                              link_ctl_wr;
  wire logic                              phy_wr;
  wire logic [AW-1:0]                     new_act;
  wire logic                              se_start;
  wire logic [AW-1:0]                     pend_act;
  wire logic                              se_busy;
  wire logic                              se_fire;

  logic                                   cpl_q;
  logic                                   hot_reset_q;
  logic                                   fund_reset_q;
  logic [NP-1:0]                          link_disable_q;
  logic [NP-1:0]                          link_retrain_q;
  logic [NP-1:0]                          full_retrain_q;

  assign hit_p0   = base_is(i_addr, cfg_space_pkg::PORT0_BASE);
  assign hit_p2   = base_is(i_addr, cfg_space_pkg::PORT2_BASE);
  assign hit_p4   = base_is(i_addr, cfg_space_pkg::PORT4_BASE);
  assign hit_p6   = base_is(i_addr, cfg_space_pkg::PORT6_BASE);
  assign base_hit = hit_p0 | hit_p2 | hit_p4 | hit_p6;
  assign port_sel = {hit_p4 | hit_p6, hit_p2 | hit_p6};
  assign is_up    = hit_p0;
  // offset is the system address less its port base, with the two byte-select bits cleared
  assign offset   = i_addr[cfg_space_pkg::OFF_W-1:0] & {{(cfg_space_pkg::OFF_W-2){1'b1}}, 2'b00};
  assign defined  = base_hit && offset_defined(is_up, offset);
  assign sts_hit  = defined && is_up && (offset == cfg_space_pkg::OFF_SW_STS);

  // storage is selected by system address, one word per defined offset of each port
  assign mem_addr = {port_sel, offset[cfg_space_pkg::IDX_W+1:2]};
  assign mem_we   = i_wr && defined && !sts_hit;
  assign ovr_en   = !defined || sts_hit;
  assign ovr_data = sts_hit ? {13'h0000, pend_act, se_busy} : cfg_space_pkg::RDATA_RESET;

  assign def_wr      = i_wr && defined;
  assign sw_ctl_wr   = def_wr && is_up && (offset == cfg_space_pkg::OFF_SW_CTL);
  assign link_ctl_wr = def_wr && (offset == cfg_space_pkg::OFF_LINK_CTL);
  assign phy_wr      = def_wr && (offset == cfg_space_pkg::OFF_PHY_LSTATE0);

  assign new_act[cfg_space_pkg::ACT_HOT]  = sw_ctl_wr && i_wdata[cfg_space_pkg::HOT_RESET_BIT];
  assign new_act[cfg_space_pkg::ACT_FUND] = sw_ctl_wr && i_wdata[cfg_space_pkg::FUND_RESET_BIT];

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port_act
      localparam int B = cfg_space_pkg::ACT_PORT0 + p * cfg_space_pkg::ACT_PER_PORT;
      wire logic sel;
      wire logic dis;
      assign sel = (port_sel == cfg_space_pkg::PORT_W'(p));
      assign dis = i_wdata[cfg_space_pkg::LINK_DISABLE_BIT];
      // a disable write only acts when it changes the applied level
      assign new_act[B + cfg_space_pkg::ACT_DIS_UPD] = link_ctl_wr && sel && (dis != link_disable_q[p]);
      assign new_act[B + cfg_space_pkg::ACT_DIS_VAL] = link_ctl_wr && sel && dis;
      assign new_act[B + cfg_space_pkg::ACT_RETRAIN] =
        link_ctl_wr && sel && i_wdata[cfg_space_pkg::LINK_RETRAIN_BIT];
      assign new_act[B + cfg_space_pkg::ACT_FULL] =
        phy_wr && sel && i_wdata[cfg_space_pkg::FULL_RETRAIN_BIT];

      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          link_disable_q[p] <= 1'b0;
          link_retrain_q[p] <= 1'b0;
          full_retrain_q[p] <= 1'b0;
        end else begin
          if (se_fire && pend_act[B + cfg_space_pkg::ACT_DIS_UPD]) begin
            link_disable_q[p] <= pend_act[B + cfg_space_pkg::ACT_DIS_VAL];
          end
          link_retrain_q[p] <= se_fire && pend_act[B + cfg_space_pkg::ACT_RETRAIN];
          full_retrain_q[p] <= se_fire && pend_act[B + cfg_space_pkg::ACT_FULL];
        end
      end
    end
  endgenerate

  assign se_start = |new_act;

  cfg_word_mem u_mem (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_addr     (mem_addr),
    .i_we       (mem_we),
    .i_wdata    (i_wdata),
    .i_re       (i_rd),
    .i_ovr_en   (ovr_en),
    .i_ovr_data (ovr_data),
    .o_rdata_q  (o_rdata)
  );

  // the completion leaves long before the action; a slow partner loses it
  side_effect_timer #(
    .DELAY_CYCLES (SIDE_EFFECT_DELAY)
  ) u_timer (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_start    (se_start),
    .i_action   (new_act),
    .o_action_q (pend_act),
    .o_busy_q   (se_busy),
    .o_fire     (se_fire)
  );

  // every write completes, defined or not
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cpl_q        <= 1'b0;
      hot_reset_q  <= 1'b0;
      fund_reset_q <= 1'b0;
    end else begin
      cpl_q        <= i_wr;
      hot_reset_q  <= se_fire && pend_act[cfg_space_pkg::ACT_HOT];
      fund_reset_q <= se_fire && pend_act[cfg_space_pkg::ACT_FUND];
    end
  end

  assign o_cpl          = cpl_q;
  assign o_hot_reset    = hot_reset_q;
  assign o_fund_reset   = fund_reset_q;
  assign o_link_disable = link_disable_q;
  assign o_link_retrain = link_retrain_q;
  assign o_full_retrain = full_retrain_q;

  // helper: cycles since the last side-effect trigger, saturating
  logic [cfg_space_pkg::DELAY_CNT_W:0] since_start_q;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      since_start_q <= '0;
    end else if (se_start) begin
      since_start_q <= '0;
    end else if (!(&since_start_q)) begin
      since_start_q <= since_start_q + 18'h0_0001;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  undef_read_zero_a: assert property (
    i_rd && !defined |=> o_rdata == '0
  ) else $error("undefined offset read returned nonzero data");

  bad_base_zero_a: assert property (
    i_rd && !base_hit |=> o_rdata == '0 && !o_cpl
  ) else $error("unmatched port base read returned nonzero data");

  undef_write_quiet_a: assert property (
    i_wr && !defined |-> !mem_we && !se_start ##1 o_cpl
  ) else $error("undefined offset write stored data or caused an action");

  cpl_before_act_a: assert property (
    se_start |=> o_cpl && !o_hot_reset && !o_fund_reset && o_link_retrain == '0 && o_full_retrain == '0
  ) else $error("side effect ran before or without its completion");

  act_delay_exact_a: assert property (
    se_fire |-> since_start_q == (cfg_space_pkg::DELAY_CNT_W+1)'(DLY_M1)
  ) else $error("side effect released at the wrong delay");

  hot_reset_go_a: assert property (
    $rose(o_hot_reset) |-> $past(pend_act[cfg_space_pkg::ACT_HOT]) && $past(se_fire)
  ) else $error("hot reset pulse without a pending hot reset");

  up_only_regs_a: assert property (
    i_rd && !is_up && offset >= cfg_space_pkg::OFF_SW_CTL && offset <= cfg_space_pkg::OFF_TEST_MODE
      |=> o_rdata == '0
  ) else $error("switch-wide register visible in a downstream port");

  msi_down_only_a: assert property (
    i_rd && is_up && offset >= cfg_space_pkg::OFF_MSI_FIRST && offset <= cfg_space_pkg::OFF_MSI_LAST
      |=> o_rdata == '0
  ) else $error("MSI capability visible in the upstream port");

  retrain_follows_a: assert property (
    se_fire && pend_act[cfg_space_pkg::ACT_PORT0 + cfg_space_pkg::ACT_RETRAIN] |=> o_link_retrain[0] ##1 !o_link_retrain[0]
  ) else $error("port 0 retrain did not pulse once");

  bad_base_quiet_a: assert property (
    i_wr && !base_hit |-> !mem_we && !se_start
  ) else $error("unmatched port base write stored data or caused an action");

  cpl_every_write_a: assert property (
    i_wr |=> o_cpl
  ) else $error("write finished without a completion pulse");

  cpl_only_write_a: assert property (
    !i_wr |=> !o_cpl
  ) else $error("completion pulse without a write");

  read_hold_a: assert property (
    !i_rd && !i_rst |=> $stable(o_rdata)
  ) else $error("read data changed without a read");

  fund_reset_go_a: assert property (
    $rose(o_fund_reset) |-> $past(pend_act[cfg_space_pkg::ACT_FUND]) && $past(se_fire)
  ) else $error("fundamental reset pulse without a pending fundamental reset");

  pulse_after_fire_a: assert property (
    o_link_retrain != '0 || o_full_retrain != '0 |-> $past(se_fire)
  ) else $error("retrain pulse without a released action");

  disable_hold_a: assert property (
    !se_fire && !i_rst |=> $stable(o_link_disable)
  ) else $error("link disable moved without a released action");

  pend_clear_a: assert property (
    se_fire |=> !se_busy && pend_act == '0
  ) else $error("released actions still pending");

  hot_pulse_once_a: assert property (
    o_hot_reset |=> !o_hot_reset
  ) else $error("hot reset pulse longer than one cycle");

  down_sw_quiet_a: assert property (
    i_wr && !is_up && offset == cfg_space_pkg::OFF_SW_CTL |-> !se_start && !mem_we
  ) else $error("switch control write acted in a downstream port");

  up_msi_quiet_a: assert property (
    i_wr && is_up && offset >= cfg_space_pkg::OFF_MSI_FIRST && offset <= cfg_space_pkg::OFF_MSI_LAST
      |-> !mem_we
  ) else $error("MSI capability write stored in the upstream port");

  retrain_arms_a: assert property (
    i_wr && defined && offset == cfg_space_pkg::OFF_LINK_CTL && i_wdata[cfg_space_pkg::LINK_RETRAIN_BIT]
      |-> se_start
  ) else $error("link retrain write did not arm the delay");

  full_arms_a: assert property (
    i_wr && defined && offset == cfg_space_pkg::OFF_PHY_LSTATE0 && i_wdata[cfg_space_pkg::FULL_RETRAIN_BIT]
      |-> se_start
  ) else $error("full link retrain write did not arm the delay");

  hot_arms_a: assert property (
    i_wr && is_up && offset == cfg_space_pkg::OFF_SW_CTL && i_wdata[cfg_space_pkg::HOT_RESET_BIT]
      |-> se_start
  ) else $error("hot reset write did not arm the delay");

  plain_write_quiet_a: assert property (
    i_wr && offset != cfg_space_pkg::OFF_LINK_CTL && offset != cfg_space_pkg::OFF_PHY_LSTATE0 &&
      offset != cfg_space_pkg::OFF_SW_CTL |-> !se_start
  ) else $error("write to a field without side effect armed the delay");

  hot_reset_cover: cover property (se_start && new_act[cfg_space_pkg::ACT_HOT] ##1 o_cpl);
  fire_cover:      cover property (se_fire ##1 (o_hot_reset || o_link_retrain != '0));
  undef_rd_cover:  cover property (i_rd && base_hit && !defined);
  status_rd_cover: cover property (i_rd && sts_hit && se_busy);
  disable_cover:   cover property (se_fire ##1 $changed(o_link_disable));

endmodule : port_config_space_decode
`default_nettype wire

/* File: verilog/side_effect_timer.sv */
// collects side-effect actions and releases them after a fixed delay
// assumes i_start marks the write cycle; the completion leaves one cycle later
`timescale 1ns/1ps
`default_nettype none
module side_effect_timer #(
  parameter int DELAY_CYCLES = cfg_space_pkg::SIDE_EFFECT_CYCLES
) (
  input  wire logic                              i_clock,
  input  wire logic                              i_rst,
  input  wire logic                              i_start,
  input  wire logic [cfg_space_pkg::ACT_W-1:0]   i_action,
  output logic      [cfg_space_pkg::ACT_W-1:0]   o_action_q,
  output logic                                   o_busy_q,
  output logic                                   o_fire
);

  localparam logic [cfg_space_pkg::DELAY_CNT_W-1:0] LOAD = cfg_space_pkg::DELAY_CNT_W'(DELAY_CYCLES);
  localparam logic [cfg_space_pkg::DELAY_CNT_W-1:0] LAST = 17'h0_0001;

  logic [cfg_space_pkg::DELAY_CNT_W-1:0] cnt_q;

  assign o_fire = o_busy_q && (cnt_q == LAST) && !i_start;

  // a new trigger merges and restarts the wait, so no action ever runs early
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt_q      <= '0;
      o_busy_q   <= 1'b0;
      o_action_q <= cfg_space_pkg::ACT_RESET;
    end else if (i_start) begin
      cnt_q      <= LOAD;
      o_busy_q   <= 1'b1;
      o_action_q <= o_action_q | i_action;
    end else if (o_fire) begin
      cnt_q      <= '0;
      o_busy_q   <= 1'b0;
      o_action_q <= cfg_space_pkg::ACT_RESET;
    end else if (o_busy_q) begin
      cnt_q <= cnt_q - LAST;
    end
  end

endmodule : side_effect_timer
`default_nettype wire
